// *** odsd_pkg.sv ***
// Constants, types and helpers shared by the octal driver serial control block
package odsd_pkg;

  localparam int          NCH       = 8;
  localparam int          WORD_W    = 16;
  localparam int          CNT_W     = 10;
  localparam int          NPAR      = 4;
  localparam int          LIMP_NCH  = 4;

  localparam logic [1:0]  CMD_STANDBY  = 2'h0;
  localparam logic [1:0]  CMD_PARALLEL = 2'h1;
  localparam logic [1:0]  CMD_ON       = 2'h2;
  localparam logic [1:0]  CMD_OFF      = 2'h3;

  localparam logic [WORD_W-1:0] CMD_RST   = 16'hFFFF;
  localparam logic [NCH-1:0]    FAULT_RST = 8'h00;
  localparam logic              TER_RST   = 1'b1;
  localparam logic [CNT_W-1:0]  CNT_MAX   = 10'h3FF;
  localparam logic [CNT_W-1:0]  CNT_MIN   = 10'h010;

  // Positions in the synchroniser vector
  localparam int          SY_CS   = 0;
  localparam int          SY_LH   = 1;
  localparam int          SY_EN   = 2;
  localparam int          SY_TOG  = 3;
  localparam int          SY_PAR  = 4;
  localparam int          SY_OVL  = 8;
  localparam int          SY_OVT  = 16;
  localparam int          SY_OPL  = 24;
  localparam int          SY_W    = 32;
  // Chip-select idles high, so its stages reset high to avoid a false frame end
  localparam logic [SY_W-1:0] SYNC_RST = 32'h00000001;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             tog;
    logic             so_bit;
  } odsd_link_s;

  localparam odsd_link_s LINK_RST = '{cnt: 10'h000, tog: 1'b0, so_bit: 1'b0};

  typedef struct packed {
    logic [SY_W-1:0]   sync1;
    logic [SY_W-1:0]   sync2;
    logic              cs_prev;
    logic              en_prev;
    logic              limp_prev;
    logic              tog_seen;
    logic [WORD_W-1:0] cmd;
    logic [NCH-1:0]    dn;
    logic [NCH-1:0]    ol;
    logic [NCH-1:0]    drv;
    logic [NCH-1:0]    dg;
    logic              frame_error_flag;
    logic              powerup;
    logic [WORD_W-1:0] snap;
    logic              snap_ter;
  } odsd_ctrl_s;

  localparam odsd_ctrl_s CTRL_RST = '{
    sync1: SYNC_RST, sync2: SYNC_RST, cs_prev: 1'b1, en_prev: 1'b0, limp_prev: 1'b0,
    tog_seen: 1'b0, cmd: CMD_RST, dn: FAULT_RST, ol: FAULT_RST, drv: 8'h00, dg: 8'h00,
    frame_error_flag: TER_RST, powerup: 1'b1, snap: 16'h0000, snap_ter: TER_RST};

  // Sixteen or more and a whole number of bytes
  function automatic logic frame_ok(input logic [CNT_W-1:0] c);
    return (c >= CNT_MIN) && (c[2:0] == 3'h0);
  endfunction : frame_ok

  // Channels whose two-bit command equals code
  function automatic logic [NCH-1:0] cmd_match(input logic [WORD_W-1:0] cmd, input logic [1:0] code);
    logic [NCH-1:0] m;
    m = '0;
    for (int i = 0; i < NCH; i++) begin
      m[i] = (cmd[2*i +: 2] == code);
    end
    return m;
  endfunction : cmd_match

  // Odd bits open load, even bits overload or over-temperature
  function automatic logic [WORD_W-1:0] fault_pack(input logic [NCH-1:0] ol, input logic [NCH-1:0] dn);
    logic [WORD_W-1:0] w;
    w = '0;
    for (int i = 0; i < NCH; i++) begin
      w[2*i+1] = ol[i];
      w[2*i]   = dn[i];
    end
    return w;
  endfunction : fault_pack

endpackage : odsd_pkg

// *** odsd_link.sv ***
// Serial-clock side of the port: shifter, bit counter and output mux
`timescale 1ns/1ns
module odsd_link (
  input  wire logic                      sclk_i,
  input  wire logic                      resetn_i,
  input  wire logic                      chip_select_n_i,
  input  wire logic                      serial_in_i,
  input  wire logic [odsd_pkg::WORD_W-1:0] fault_word_i,
  input  wire logic                      frame_error_i,
  output logic                           serial_out_o,
  output logic                           serial_out_en_n_o,
  output logic [odsd_pkg::WORD_W-1:0]    rx_word_o,
  output logic [odsd_pkg::CNT_W-1:0]     bit_count_o,
  output logic                           frame_toggle_o
);

  odsd_pkg::odsd_link_s          s;
  odsd_pkg::odsd_link_s          next_s;
  logic [odsd_pkg::WORD_W-1:0]   rx;
  logic                          started;
  logic [odsd_pkg::CNT_W-1:0]    cnt_eff;

  ////////////////////////////////////////////////////////////////////////////
  // Input shifter, sampled on the falling edge, only while selected
  always_ff @(negedge sclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx <= 16'h0000;
    end else if (!chip_select_n_i) begin
      rx <= {rx[odsd_pkg::WORD_W-2:0], serial_in_i};
    end
  end

  // Deselect clears the first-edge flag, so the count restarts at 1 on the first clock rise after the select fall
  always_ff @(posedge sclk_i or negedge resetn_i or posedge chip_select_n_i) begin
    if (!resetn_i) begin
      started <= 1'b0;
    end else if (chip_select_n_i) begin
      started <= 1'b0;
    end else begin
      started <= 1'b1;
    end
  end

  assign cnt_eff = started ? s.cnt : 10'h000;

  always_comb begin
    next_s = s;
    if (!chip_select_n_i) begin
      next_s.cnt = started ? ((s.cnt == odsd_pkg::CNT_MAX) ? s.cnt : s.cnt + 10'h001) : 10'h001;
      next_s.tog = started ? s.tog : ~s.tog;
      if (cnt_eff < odsd_pkg::CNT_MIN) begin
        next_s.so_bit = fault_word_i[4'hF - cnt_eff[3:0]];
      end else begin
        next_s.so_bit = rx[odsd_pkg::WORD_W-1];
      end
    end
  end

  always_ff @(posedge sclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s <= odsd_pkg::LINK_RST;
    end else begin
      s <= next_s;
    end
  end

  // Before the first rise the flag is ORed with the upstream input
  assign serial_out_o      = started ? s.so_bit : (frame_error_i | serial_in_i);
  assign serial_out_en_n_o = chip_select_n_i;
  // Stable while the clock idles after deselect; read then by the system side
  assign rx_word_o         = rx;
  assign bit_count_o       = s.cnt;
  assign frame_toggle_o    = s.tog;

  property p_first_bit;
    @(posedge sclk_i) disable iff (!resetn_i || chip_select_n_i)
      (!started) |=> (s.so_bit == $past(fault_word_i[15]));
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("first bit out is not fault word MSB");

  property p_chain;
    @(posedge sclk_i) disable iff (!resetn_i || chip_select_n_i)
      (started && (s.cnt >= odsd_pkg::CNT_MIN)) |=> (s.so_bit == $past(rx[15]));
  endproperty
  a_chain: assert property (p_chain) else $error("chained data not delayed by sixteen");

endmodule : odsd_link

// *** odsd_ctrl.sv ***
// Top of the octal driver serial control: frame check, input register, faults
`timescale 1ns/1ns
module odsd_ctrl (
  input  wire logic                          clk_sys_i,
  input  wire logic                          resetn_i,
  input  wire logic                          sclk_i,
  input  wire logic                          chip_select_n_i,
  input  wire logic                          serial_in_i,
  output logic                               serial_out_o,
  output logic                               serial_out_en_n_o,
  input  wire logic                          enable_pin_i,
  input  wire logic                          limp_home_pin_i,
  input  wire logic [odsd_pkg::NPAR-1:0]     parallel_ctrl_pin_i,
  input  wire logic [odsd_pkg::NCH-1:0]      overload_i,
  input  wire logic [odsd_pkg::NCH-1:0]      overtemp_i,
  input  wire logic [odsd_pkg::NCH-1:0]      open_load_i,
  output logic [odsd_pkg::NCH-1:0]           driver_output_o,
  output logic [odsd_pkg::NCH-1:0]           diag_current_en_o,
  output logic                               frame_error_flag_o,
  output logic [odsd_pkg::WORD_W-1:0]        fault_word_o
);

  odsd_pkg::odsd_ctrl_s              s;
  odsd_pkg::odsd_ctrl_s              next_s;
  logic [odsd_pkg::SY_W-1:0]         async_in;
  logic [odsd_pkg::WORD_W-1:0]       rx_word;
  logic [odsd_pkg::CNT_W-1:0]        bit_count;
  logic                              frame_toggle;
  logic                              cs_s;
  logic                              limp_s;
  logic                              en_s;
  logic                              tog_s;
  logic [odsd_pkg::NPAR-1:0]         par_s;
  logic [odsd_pkg::NCH-1:0]          ovl_s;
  logic [odsd_pkg::NCH-1:0]          ovt_s;
  logic [odsd_pkg::NCH-1:0]          opl_s;
  logic                              cs_rise;
  logic                              frame_evt;
  logic                              len_ok;
  logic                              en_rise;
  logic                              limp_fall;
  logic                              lowiq;
  logic [odsd_pkg::NCH-1:0]          sb;
  logic [odsd_pkg::NCH-1:0]          clr;
  logic [odsd_pkg::NCH-1:0]          hot;
  logic [odsd_pkg::NCH-1:0]          drv_raw;
  logic [odsd_pkg::NCH-1:0]          dg_raw;

  ////////////////////////////////////////////////////////////////////////////
  // Link domain
  odsd_link u_link (
    .sclk_i            (sclk_i),
    .resetn_i          (resetn_i),
    .chip_select_n_i   (chip_select_n_i),
    .serial_in_i       (serial_in_i),
    .fault_word_i      (s.snap),
    .frame_error_i     (s.snap_ter),
    .serial_out_o      (serial_out_o),
    .serial_out_en_n_o (serial_out_en_n_o),
    .rx_word_o         (rx_word),
    .bit_count_o       (bit_count),
    .frame_toggle_o    (frame_toggle)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Synchronised views of pins and of the link toggle
  assign async_in = {open_load_i, overtemp_i, overload_i, parallel_ctrl_pin_i,
                     frame_toggle, enable_pin_i, limp_home_pin_i, chip_select_n_i};

  assign cs_s   = s.sync2[odsd_pkg::SY_CS];
  assign limp_s = s.sync2[odsd_pkg::SY_LH];
  assign en_s   = s.sync2[odsd_pkg::SY_EN];
  assign tog_s  = s.sync2[odsd_pkg::SY_TOG];
  assign par_s  = s.sync2[odsd_pkg::SY_PAR +: odsd_pkg::NPAR];
  assign ovl_s  = s.sync2[odsd_pkg::SY_OVL +: odsd_pkg::NCH];
  assign ovt_s  = s.sync2[odsd_pkg::SY_OVT +: odsd_pkg::NCH];
  assign opl_s  = s.sync2[odsd_pkg::SY_OPL +: odsd_pkg::NCH];

  ////////////////////////////////////////////////////////////////////////////
  // Frame end and mode events
  assign cs_rise   = cs_s & ~s.cs_prev;
  // A frame with no clocks leaves the toggle alone: a pure flag read
  assign frame_evt = cs_rise & (tog_s != s.tog_seen);
  // Count and shifter are quiet here because both only change while chip select is low
  assign len_ok    = odsd_pkg::frame_ok(bit_count);
  assign en_rise   = en_s & ~s.en_prev & ~limp_s;
  assign limp_fall = ~limp_s & s.limp_prev;
  assign lowiq     = ~en_s & ~limp_s;
  assign sb        = odsd_pkg::cmd_match(s.cmd, odsd_pkg::CMD_STANDBY) & {odsd_pkg::NCH{~limp_s}};
  assign clr       = sb | {odsd_pkg::NCH{lowiq | limp_fall}};
  assign hot       = s.drv & ovt_s;

  // Driver and sink-current requests before the latch-off gate
  always_comb begin
    drv_raw = '0;
    dg_raw  = '0;
    for (int i = 0; i < odsd_pkg::NCH; i++) begin
      if (limp_s) begin
        drv_raw[i] = (i < odsd_pkg::LIMP_NCH) ? par_s[i % odsd_pkg::NPAR] : 1'b0;
        dg_raw[i]  = 1'b0;
      end else if (!en_s) begin
        drv_raw[i] = 1'b0;
        dg_raw[i]  = 1'b0;
      end else begin
        unique case (s.cmd[2*i +: 2])
          odsd_pkg::CMD_STANDBY: begin
            drv_raw[i] = 1'b0;
            dg_raw[i]  = 1'b0;
          end
          odsd_pkg::CMD_PARALLEL: begin
            drv_raw[i] = par_s[i % odsd_pkg::NPAR];
            dg_raw[i]  = 1'b1;
          end
          odsd_pkg::CMD_ON: begin
            drv_raw[i] = 1'b1;
            dg_raw[i]  = 1'b0;
          end
          odsd_pkg::CMD_OFF: begin
            drv_raw[i] = 1'b0;
            dg_raw[i]  = ~s.powerup;
          end
        endcase
      end
    end
  end

  always_comb begin
    next_s       = s;
    next_s.sync1 = async_in;
    next_s.sync2 = s.sync1;
    next_s.cs_prev   = cs_s;
    next_s.en_prev   = en_s;
    next_s.limp_prev = limp_s;
    if (frame_evt) begin
      next_s.tog_seen = tog_s;
      // Commands are ignored in limp-home
      if (!limp_s) begin
        if (len_ok) begin
          next_s.cmd     = rx_word;
          next_s.frame_error_flag     = 1'b0;
          next_s.powerup = 1'b0;
        end else begin
          next_s.frame_error_flag = 1'b1;
        end
      end
    end
    if (lowiq) begin
      next_s.cmd = odsd_pkg::CMD_RST;
    end
    if (en_rise) begin
      next_s.frame_error_flag     = 1'b1;
      next_s.powerup = 1'b1;
    end
    if (limp_fall) begin
      next_s.cmd     = odsd_pkg::CMD_RST;
      next_s.frame_error_flag     = 1'b1;
      next_s.powerup = 1'b1;
    end
    // Set terms come last so a fault in a clearing cycle survives
    next_s.dn  = (s.dn & ~clr) | (s.drv & (ovl_s | ovt_s));
    next_s.ol  = (s.ol & ~clr) | (~s.drv & s.dg & opl_s);
    next_s.drv = drv_raw & ~s.dn;
    next_s.dg  = dg_raw;
    // Frozen while selected; the link reads it a few cycles after the select fall
    if (cs_s) begin
      next_s.snap     = odsd_pkg::fault_pack(s.ol, s.dn);
      next_s.snap_ter = s.frame_error_flag;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s <= odsd_pkg::CTRL_RST;
    end else begin
      s <= next_s;
    end
  end

  // Sink current only flows while the driver is off
  assign driver_output_o    = s.drv;
  assign diag_current_en_o  = s.dg & ~s.drv;
  assign frame_error_flag_o = s.frame_error_flag;
  assign fault_word_o       = s.snap;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!resetn_i);

  property p_ovt_latch;
    (hot != 8'h00) |=> ((s.dn & $past(hot)) == $past(hot));
  endproperty
  a_ovt_latch: assert property (p_ovt_latch) else $error("hot channel not latched");

  property p_latch_off;
    1'b1 |=> ((s.drv & $past(s.dn)) == 8'h00);
  endproperty
  a_latch_off: assert property (p_latch_off) else $error("latched channel driven on");

  property p_ol_off;
    1'b1 |=> ((s.ol & ~$past(s.ol) & $past(s.drv)) == 8'h00);
  endproperty
  a_ol_off: assert property (p_ol_off) else $error("open load set while driver on");

  property p_powerup;
    (s.powerup && (s.cmd == odsd_pkg::CMD_RST)) |=> (s.dg == 8'h00);
  endproperty
  a_powerup: assert property (p_powerup) else $error("sink current on at power-up");

  property p_standby;
    ((sb & $past(sb) & $past(sb, 2)) != 8'h00) |->
      (((s.dn | s.ol) & sb & $past(sb) & $past(sb, 2)) == 8'h00);
  endproperty
  a_standby: assert property (p_standby) else $error("standby did not clear faults");

  sequence s_lowiq;
    (!en_s && !limp_s) [*3];
  endsequence

  property p_lowiq;
    s_lowiq |-> (((s.dn | s.ol) == 8'h00) && (s.drv == 8'h00));
  endproperty
  a_lowiq: assert property (p_lowiq) else $error("enable low did not clear faults");

  sequence s_steady_frame;
    frame_evt && !limp_s && en_s && s.en_prev && !s.limp_prev;
  endsequence

  property p_frame;
    s_steady_frame |=> ((s.frame_error_flag == !$past(len_ok)) &&
      (s.cmd == ($past(len_ok) ? $past(rx_word) : $past(s.cmd))));
  endproperty
  a_frame: assert property (p_frame) else $error("frame check or load wrong");

  property p_ter_read;
    (cs_rise && (tog_s == s.tog_seen) && !limp_s && en_s && s.en_prev && !s.limp_prev)
      |=> ((s.frame_error_flag == $past(s.frame_error_flag)) && (s.cmd == $past(s.cmd)));
  endproperty
  a_ter_read: assert property (p_ter_read) else $error("flag read changed state");

  property p_limp_exit;
    limp_fall |=> (s.frame_error_flag && (s.cmd == odsd_pkg::CMD_RST) && s.powerup);
  endproperty
  a_limp_exit: assert property (p_limp_exit) else $error("limp-home exit not handled");

endmodule : odsd_ctrl

// *** odsd_spi_host.sv ***
// Host model: drives select, serial clock and data, captures the response
`timescale 1ns/1ns
module odsd_spi_host (
  output logic      sclk_o,
  output logic      chip_select_n_o,
  output logic      serial_in_o,
  input  wire logic serial_out_i
);
  localparam int HALF = 80;

  initial begin
    sclk_o          = 1'b0;
    chip_select_n_o = 1'b1;
    serial_in_o     = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One frame of n bits, MSB first; n of zero is a bare flag read
  task automatic xfer(input int n, input logic [63:0] tx, input logic lead,
                      output logic [63:0] rx, output logic flag);
    rx = 64'h0;
    serial_in_o = lead;
    #(HALF) chip_select_n_o = 1'b0;
    #(HALF) flag = serial_out_i;
    for (int i = n - 1; i >= 0; i--) begin
      sclk_o = 1'b1;
      serial_in_o = tx[i];
      #(HALF) rx[i] = serial_out_i;
      sclk_o = 1'b0;
      #(HALF);
    end
    #(HALF) chip_select_n_o = 1'b1;
    // Released line shows the inverse so a stale value never looks valid
    serial_in_o = ~serial_in_o;
    #(HALF);
  endtask : xfer

  // Clock pulses while deselected, as when another device is addressed
  task automatic stray(input int n);
    for (int i = 0; i < n; i++) begin
      serial_in_o = ~serial_in_o;
      #(HALF) sclk_o = 1'b1;
      #(HALF) sclk_o = 1'b0;
    end
  endtask : stray
endmodule : odsd_spi_host

// *** odsd_ctrl_tb_top.sv ***
// Self-checking bench for the octal driver serial control block
`timescale 1ns/1ns
module odsd_ctrl_tb_top;
  logic        clk_sys_i  = 1'b0;
  logic        resetn_i   = 1'b0;
  logic        sclk, csn, si, so, so_en_n, flag;
  logic        enable_pin = 1'b1;
  logic        limp_pin   = 1'b0;
  logic [3:0]  par        = 4'h0;
  logic [7:0]  ovl = 8'h00, ovt = 8'h00, opl = 8'h00, drv, diag;
  logic [15:0] fw;
  logic [15:0] ecmd  = 16'hFFFF;
  logic [7:0]  edn   = 8'h00, eol = 8'h00;
  logic        eflag = 1'b1, epow = 1'b1;
  int          fails = 0, checks = 0, cyc = 0, seed;
  int          bad_len [6] = '{8, 12, 15, 17, 20, 1};
  int          good_len [4] = '{16, 24, 32, 40};

  always #5 clk_sys_i = ~clk_sys_i;

  odsd_ctrl odsd_ctrl_i (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .sclk_i(sclk), .chip_select_n_i(csn),
    .serial_in_i(si), .serial_out_o(so), .serial_out_en_n_o(so_en_n), .enable_pin_i(enable_pin),
    .limp_home_pin_i(limp_pin), .parallel_ctrl_pin_i(par), .overload_i(ovl), .overtemp_i(ovt),
    .open_load_i(opl), .driver_output_o(drv), .diag_current_en_o(diag),
    .frame_error_flag_o(flag), .fault_word_o(fw));

  odsd_spi_host odsd_spi_host_i (
    .sclk_o(sclk), .chip_select_n_o(csn), .serial_in_o(si), .serial_out_i(so));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("Counts: checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  // Longest expected run is about 8000 cycles
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails = fails + 1;
      summarize();
    end
  end

  task automatic chk_vec(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_vec

  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  function automatic logic [15:0] fword();
    logic [15:0] w;
    for (int i = 0; i < 8; i++) begin
      w[2*i+1] = eol[i];
      w[2*i]   = edn[i];
    end
    return w;
  endfunction : fword

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check_state();
    logic [7:0] d, g;
    for (int i = 0; i < 8; i++) begin
      d[i] = !edn[i] && (ecmd[2*i+:2] == odsd_pkg::CMD_ON || (ecmd[2*i+:2] == odsd_pkg::CMD_PARALLEL && par[i%4]));
      g[i] = !d[i] && !epow && (ecmd[2*i+:2] == odsd_pkg::CMD_OFF || ecmd[2*i+:2] == odsd_pkg::CMD_PARALLEL);
    end
    chk_vec(64'(drv), 64'(d));
    chk_vec(64'(diag), 64'(g));
    chk_bit(flag, eflag);
    chk_vec(64'(fw), 64'(fword()));
    // Output stays released while deselected
    chk_bit(so_en_n, 1'b1);
  endtask : check_state

  // Frame through the host, then model what the block must have taken
  task automatic send(input int n, input logic [63:0] tx, input logic lead);
    logic [63:0] rx;
    logic        fl;
    odsd_spi_host_i.xfer(n, tx, lead, rx, fl);
    chk_bit(fl, eflag | lead);
    if (n >= 16) begin
      chk_vec(64'(rx[n-1-:16]), 64'(fword()));
      chk_vec((rx ^ (tx >> 16)) & ((64'h1 << (n - 16)) - 64'h1), 64'h0);
    end
    if (n >= 16 && n % 8 == 0) begin
      ecmd  = tx[15:0];
      eflag = 1'b0;
      epow  = 1'b0;
      for (int i = 0; i < 8; i++) begin
        if (ecmd[2*i+:2] == odsd_pkg::CMD_STANDBY) begin
          edn[i] = 1'b0;
          eol[i] = 1'b0;
        end
      end
    end else if (n != 0) begin
      eflag = 1'b1;
    end
    repeat (10) @(negedge clk_sys_i);
  endtask : send

  task automatic settle();
    repeat (10) @(negedge clk_sys_i);
  endtask : settle

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = $urandom(32'hB3686F16);
    repeat (16) @(negedge clk_sys_i);
    resetn_i = 1'b1;
    settle();
    check_state();
    send(0, 64'h0, 1'b0);
    check_state();
    // Broken lengths interleaved with random valid commands
    foreach (bad_len[k]) begin
      par = 4'($urandom());
      send(bad_len[k], {$urandom(), $urandom()}, 1'b0);
      check_state();
      send(16, {32'h0, $urandom()}, 1'b0);
      check_state();
    end
    foreach (good_len[k]) begin
      send(good_len[k], {$urandom(), $urandom()}, 1'b0);
      check_state();
    end
    send(0, 64'h0, 1'b1);
    send(0, 64'h0, 1'b0);
    odsd_spi_host_i.stray(20);
    settle();
    check_state();
    // Thermal and overload latch-off on two channels
    send(16, 64'hAAAA, 1'b0);
    ovt = 8'h04;
    ovl = 8'h40;
    settle();
    ovt = 8'h00;
    ovl = 8'h00;
    edn = 8'h44;
    settle();
    check_state();
    send(16, 64'hAAAA, 1'b0);
    check_state();
    send(16, 64'hAA8A, 1'b0);
    check_state();
    send(16, 64'hAAAA, 1'b0);
    check_state();
    // Open load only while off, and it never blocks switching
    send(16, 64'hFFFF, 1'b0);
    opl = 8'h11;
    settle();
    opl = 8'h00;
    eol = 8'h11;
    settle();
    check_state();
    send(16, 64'hFFFA, 1'b0);
    opl = 8'h02;
    settle();
    opl = 8'h00;
    settle();
    check_state();
    // Enable low then high
    enable_pin = 1'b0;
    settle();
    enable_pin = 1'b1;
    settle();
    {ecmd, edn, eol, eflag, epow} = {16'hFFFF, 8'h00, 8'h00, 1'b1, 1'b1};
    check_state();
    // Limp-home entry and exit
    send(16, 64'hAAAA, 1'b0);
    ovl = 8'h01;
    settle();
    ovl = 8'h00;
    limp_pin = 1'b1;
    settle();
    limp_pin = 1'b0;
    settle();
    {ecmd, edn, eol, eflag, epow} = {16'hFFFF, 8'h00, 8'h00, 1'b1, 1'b1};
    check_state();
    send(0, 64'h0, 1'b0);
    summarize();
  end
endmodule : odsd_ctrl_tb_top
